// ---- ccc_pkg.sv ----
// Package for the charge cycle controller: constants, state and carrier types.
// Assumes a 100 MHz pclk and comparator results that arrive unsynchronised.
package ccc_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS      = 10;
   localparam int TICK_PERIOD_MS     = 1000;
   localparam int TICK_CYCLES        = TICK_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int BLINK_INT_MS       = 500;
   localparam int BLINK_INT_CYCLES   = BLINK_INT_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int BLINK_HOUR_MS      = 100;
   localparam int BLINK_HOUR_CYCLES  = BLINK_HOUR_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int FILT_LEN           = 4;
   localparam int TIMER_W            = 15;
   localparam logic [TIMER_W-1:0] SEC_PER_HOUR = 15'h0E10;
   localparam logic [2:0] HOURS_INT  = 3'h3;
   localparam logic [2:0] HOURS_MIN  = 3'h2;
   localparam logic [2:0] HOURS_MAX  = 3'h6;
   localparam int QUARTER_SHIFT      = 2;

   // ***************************************************************
   // APB register map
   // ***************************************************************
   localparam int ADDR_W                 = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFF    = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFF  = 8'h04;
   localparam logic [ADDR_W-1:0] ELAPSED_OFF = 8'h08;
   localparam logic [2:0] CTRL_HOURS_RST = 3'h3;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {ST_OFF, ST_PRECHG, ST_FAST_CC, ST_CONST_V,
                             ST_FLOAT, ST_MONITOR, ST_PRE_FAULT, ST_REGULATE} ccc_state_t;

   typedef enum logic [1:0] {TM_INTERNAL, TM_EXTERNAL, TM_DISABLED} ccc_tmode_t;

   typedef struct packed {
      logic vbat_above_pre;
      logic vbat_at_float;
      logic vbat_below_rechg;
      logic iout_below_term;
      logic en_low;
      logic en_high;
      logic ntc_hi_trip;
      logic ntc_hi_ok;
      logic ntc_lo_trip;
      logic ntc_lo_ok;
      logic tim_at_supply;
      logic tim_at_ground;
      logic battery_absent_sel;
   } ccc_cmp_t;

   typedef struct packed {
      logic [15:0]  reserved;
      logic [TIMER_W-1:TIMER_W-1] spare;
      logic         enabled;
      logic         batt_absent;
      ccc_tmode_t   timer_mode;
      logic         term_latched;
      logic         pre_fault;
      logic         suspended;
      logic         out_on;
      logic         cv_mode;
      logic         precharge;
      logic         reg_mode;
      ccc_state_t   state;
   } ccc_status_t;

endpackage : ccc_pkg

// ---- ccc_filter.sv ----
// Synchroniser and agreement filter for a vector of comparator results.
// Assumes raw inputs are asynchronous to clk.
`timescale 1ns/1ps
module ccc_filter #(
   parameter int W   = 8,
   parameter int LEN = 4
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] filt_r
);
   // Each bit changes only after LEN equal samples, hiding comparator chatter
   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         logic                   s1_r, s2_r;
         logic [$clog2(LEN+1)-1:0] cnt_r;
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end else begin
               s1_r <= raw[i];
               s2_r <= s1_r;
            end
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn) begin
               cnt_r     <= '0;
               filt_r[i] <= 1'b0;
            end else if (s2_r == filt_r[i]) begin
               cnt_r <= '0;
            end else if (cnt_r == ($clog2(LEN+1))'(LEN - 1)) begin
               cnt_r     <= '0;
               filt_r[i] <= s2_r;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   endgenerate
endmodule : ccc_filter

// ---- ccc_timer.sv ----
// Charge timer: prescaled seconds counter with programmable terminal count.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/1ps
module ccc_timer
   import ccc_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               run,
   input  wire logic               clear,
   input  wire logic [TIMER_W-1:0] limit_s,
   output logic      [TIMER_W-1:0] elapsed_r,
   output logic                    expired,
   output logic                    quarter
);
   logic [31:0] pre_r;

   // Prescaler holds while stopped so suspended time is not counted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_r <= '0;
      else if (clear)
         pre_r <= '0;
      else if (run && !expired)
         pre_r <= (pre_r == 32'(TICKS - 1)) ? '0 : pre_r + 32'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         elapsed_r <= '0;
      else if (clear)
         elapsed_r <= '0;
      else if (run && !expired && pre_r == 32'(TICKS - 1))
         elapsed_r <= elapsed_r + 1'b1;
   end

   assign expired = (elapsed_r >= limit_s);
   assign quarter = (elapsed_r >= (limit_s >> QUARTER_SHIFT));
endmodule : ccc_timer

// ---- ccc_ctrl.sv ----
// Charge cycle controller top: sequencing, timer control, LED and APB registers.
// Assumes comparator results from the analog section on cmp_raw, asynchronous.
`timescale 1ns/1ps
// Operation
// - Battery at float voltage switches regulation from constant current to constant voltage.
// - Output current below termination releases the charge status LED.
// - Timer enabled: keep float charging after termination until the timer expires.
// - Timer disabled: output off as soon as termination current is reached.
// - Completed cycle turns output off and enters monitor state.
// - In monitor, battery 100 mV below float clears timer and restarts charging.
// - Output on when battery absent high; otherwise per timer and termination.
// - Timer pin at supply selects internal, grounded disables, resistor programs time.
// - Internal timer gives three hours of total charge time.
// - Programmed charge time spans two to six hours.
// - External timer setting sets the fault blink rate of the status LED.
// - Battery absent high selects regulator mode, low selects charger mode.
// - Regulator mode regulates voltage with the fast charge current limit.
// - Enable input at supply enables, at ground disables the device.
// - In charger mode, thermistor outside window suspends: output off, timer frozen, LED fault.
// - Both temperature thresholds have hysteresis against chatter.
// - Temperature back inside window resumes the cycle automatically.
// - Timer counts only output on time, excluding temperature suspension.
// - Temperature thresholds sit at thirty and seventy-five percent of supply.
// - Battery below 2.8 V charges with pre-charge current.
// - Pre-charge beyond a quarter of charge time is a fault, cleared on recovery.
// - LED release is latched per cycle, reset on recharge or input toggles.
module ccc_ctrl
   import ccc_pkg::*;
#(
   parameter int TICKS        = TICK_CYCLES,
   parameter int BLINK_INT    = BLINK_INT_CYCLES,
   parameter int BLINK_HOUR   = BLINK_HOUR_CYCLES,
   parameter int FLEN         = FILT_LEN
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic                       pready,
   output logic      [31:0]           prdata,
   output logic                       pslverr,
   input  wire ccc_pkg::ccc_cmp_t     cmp_raw,
   output logic                       out_en,
   output logic                       cv_mode,
   output logic                       precharge_sel,
   output logic                       regulator_mode,
   output logic                       charge_status_led_n_o,
   output logic                       charge_status_led_n_oe_n
);
   import ccc_pkg::*;

   // ***************************************************************
   // Comparator conditioning
   // ***************************************************************
   ccc_cmp_t cmp;
   logic     out_seen, out_en_r;
   ccc_filter #(
      .W   ($bits(ccc_cmp_t) + 1),
      .LEN (FLEN)
   ) u_filter (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     ({cmp_raw, out_en_r}), // Output copy ages with the current comparator it drives
      .filt_r  ({cmp, out_seen})
   );

   // ***************************************************************
   // Registers and state
   // ***************************************************************
   ccc_state_t         state_r, state_nxt;
   logic [2:0]         hours_r;
   logic               ntc_fault_r;
   logic               term_latch_r;
   logic               enabled_r;
   logic               absent_d_r;
   logic               led_oe_n_r;
   logic               blink_r;
   logic [31:0]        blink_cnt_r;
   logic [31:0]        prdata_r;
   logic               err_r;
   logic               cv_mode_r, pre_sel_r, reg_mode_r;
   ccc_tmode_t         tmode;
   logic [2:0]         hours_eff;
   logic [TIMER_W-1:0] limit_s;
   logic [TIMER_W-1:0] elapsed;
   logic               expired, quarter;
   logic               timer_on, charging, out_on, suspended;
   logic               enabled, new_cycle, timer_clr;
   logic [31:0]        blink_half;
   ccc_status_t        status;

   // ***************************************************************
   // Timer selection
   // ***************************************************************
   always_comb
   begin
      if (cmp.tim_at_supply)
         tmode = TM_INTERNAL;
      else if (cmp.tim_at_ground)
         tmode = TM_DISABLED;
      else
         tmode = TM_EXTERNAL;
   end

   // Programmed hours come from software, which reads out the timing resistor
   always_comb
   begin
      if (tmode == TM_INTERNAL)
         hours_eff = HOURS_INT;
      else if (hours_r < HOURS_MIN)
         hours_eff = HOURS_MIN;
      else if (hours_r > HOURS_MAX)
         hours_eff = HOURS_MAX;
      else
         hours_eff = hours_r;
   end

   assign limit_s  = TIMER_W'(hours_eff * SEC_PER_HOUR);
   assign timer_on = (tmode != TM_DISABLED);

   // ***************************************************************
   // Enable and thermistor window
   // ***************************************************************
   // Near ground disables; between the 30% and 75% points is the thermistor range
   assign enabled = !cmp.en_low;

   // Trip and recovery use separate comparators, so the window has hysteresis
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ntc_fault_r <= 1'b0;
      else if (!enabled || cmp.en_high)
         ntc_fault_r <= 1'b0;
      else if (cmp.ntc_hi_trip || cmp.ntc_lo_trip)
         ntc_fault_r <= 1'b1;
      else if (cmp.ntc_hi_ok && cmp.ntc_lo_ok)
         ntc_fault_r <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enabled_r  <= 1'b0;
         absent_d_r <= 1'b0;
      end else begin
         enabled_r  <= enabled;
         absent_d_r <= cmp.battery_absent_sel;
      end
   end

   // A rising enable or any battery-absent toggle starts a fresh cycle
   assign new_cycle = (enabled && !enabled_r) ||
                      (cmp.battery_absent_sel != absent_d_r);

   // ***************************************************************
   // Cycle sequencer
   // ***************************************************************
   assign charging  = (state_r == ST_PRECHG) || (state_r == ST_FAST_CC) ||
                      (state_r == ST_CONST_V) || (state_r == ST_FLOAT);
   assign suspended = ntc_fault_r && (charging || state_r == ST_PRE_FAULT);
   assign out_on    = (state_r == ST_REGULATE) || (charging && !ntc_fault_r);
   assign timer_clr = new_cycle || (state_r == ST_MONITOR && cmp.vbat_below_rechg) ||
                      !enabled;

   always_comb
   begin
      state_nxt = state_r;
      if (!enabled)
         state_nxt = ST_OFF;
      else if (cmp.battery_absent_sel)
         state_nxt = ST_REGULATE;
      else if (new_cycle || state_r == ST_OFF || state_r == ST_REGULATE)
         state_nxt = cmp.vbat_above_pre ? ST_FAST_CC : ST_PRECHG;
      else if (ntc_fault_r)
         state_nxt = state_r;
      else if (charging && timer_on && expired)
         state_nxt = ST_MONITOR;
      else
      begin
         case (state_r)
            ST_PRECHG:
               if (cmp.vbat_above_pre)
                  state_nxt = ST_FAST_CC;
               else if (timer_on && quarter)
                  state_nxt = ST_PRE_FAULT;
            ST_FAST_CC:
               if (!cmp.vbat_above_pre)
                  state_nxt = ST_PRECHG;
               else if (cmp.vbat_at_float)
                  state_nxt = ST_CONST_V;
            ST_CONST_V:
               if (cmp.iout_below_term)
                  state_nxt = timer_on ? ST_FLOAT : ST_MONITOR;
            ST_MONITOR:
               if (cmp.vbat_below_rechg)
                  state_nxt = cmp.vbat_above_pre ? ST_FAST_CC : ST_PRECHG;
            ST_PRE_FAULT:
               if (cmp.vbat_above_pre)
                  state_nxt = ST_FAST_CC;
            default:
               state_nxt = state_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= ST_OFF;
      else
         state_r <= state_nxt;
   end

   // ***************************************************************
   // Charge timer
   // ***************************************************************
   ccc_timer #(
      .TICKS (TICKS)
   ) u_timer (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (out_on && charging && timer_on),
      .clear     (timer_clr),
      .limit_s   (limit_s),
      .elapsed_r (elapsed),
      .expired   (expired),
      .quarter   (quarter)
   );

   // ***************************************************************
   // Regulator controls
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_en_r   <= 1'b0;
         cv_mode_r  <= 1'b0;
         pre_sel_r  <= 1'b0;
         reg_mode_r <= 1'b0;
      end else begin
         out_en_r   <= out_on;
         cv_mode_r  <= (state_r == ST_CONST_V) || (state_r == ST_FLOAT) ||
                       (state_r == ST_REGULATE);
         pre_sel_r  <= (state_r == ST_PRECHG);
         reg_mode_r <= (state_r == ST_REGULATE);
      end
   end

   assign out_en         = out_en_r;
   assign cv_mode        = cv_mode_r;
   assign precharge_sel  = pre_sel_r;
   assign regulator_mode = reg_mode_r;

   // ***************************************************************
   // Status LED
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         term_latch_r <= 1'b0;
      else if (timer_clr)
         term_latch_r <= 1'b0;
      else if (out_on && out_seen && cmp.iout_below_term)
         term_latch_r <= 1'b1;
   end

   // Slow blink avoids reading as steady on; external timer scales it
   assign blink_half = (tmode == TM_EXTERNAL) ? 32'(hours_eff) * 32'(BLINK_HOUR)
                                              : 32'(BLINK_INT);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
      end else if (blink_cnt_r >= blink_half - 32'h1) begin
         blink_cnt_r <= '0;
         blink_r     <= !blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h1;
      end
   end

   // Pin is open drain: enable low pulls it low and lights the LED
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         led_oe_n_r <= 1'b1;
      else if (suspended || state_r == ST_PRE_FAULT)
         led_oe_n_r <= !blink_r;
      else if (out_on && !term_latch_r && !cmp.iout_below_term)
         led_oe_n_r <= 1'b0;
      else
         led_oe_n_r <= 1'b1;
   end

   assign charge_status_led_n_o    = 1'b0;
   assign charge_status_led_n_oe_n = led_oe_n_r;

   // ***************************************************************
   // APB slave
   // ***************************************************************
   always_comb
   begin
      status              = '0;
      status.state        = state_r;
      status.reg_mode     = reg_mode_r;
      status.precharge    = pre_sel_r;
      status.cv_mode      = cv_mode_r;
      status.out_on       = out_en_r;
      status.suspended    = suspended;
      status.pre_fault    = (state_r == ST_PRE_FAULT);
      status.term_latched = term_latch_r;
      status.timer_mode   = tmode;
      status.batt_absent  = cmp.battery_absent_sel;
      status.enabled      = enabled;
   end

   // Read data and error are captured in setup, so access completes at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= '0;
         err_r    <= 1'b0;
      end else if (psel && !penable) begin
         err_r    <= 1'b0;
         prdata_r <= '0;
         if (paddr == CTRL_OFF)
            prdata_r <= 32'(hours_r);
         else if (paddr == STATUS_OFF)
            prdata_r <= 32'(status);
         else if (paddr == ELAPSED_OFF)
            err_r <= pwrite;
         else
            err_r <= 1'b1;
         if (paddr == ELAPSED_OFF && !pwrite)
            prdata_r <= 32'(elapsed);
         if (paddr == STATUS_OFF && pwrite)
            err_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hours_r <= CTRL_HOURS_RST;
      else if (psel && penable && pwrite && paddr == CTRL_OFF && pstrb[0])
         hours_r <= pwdata[2:0];
   end

   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = psel && penable && err_r;

endmodule : ccc_ctrl

// ---- ccc_cell_model.sv ----
// Model of one cell with its thermistor divider, feeding the comparator inputs.
// Assumes the bench sets cell voltage in mV and the divider tap in percent of supply.
`timescale 1ns/1ps
module ccc_cell_model
   import ccc_pkg::*;
(
   input  wire logic [12:0]  vbat_mv,
   input  wire logic [6:0]   ntc_pct,
   input  wire logic [1:0]   tim_pin,
   input  wire logic         taper_done,
   input  wire logic         absent,
   input  wire logic         out_en,
   output ccc_pkg::ccc_cmp_t cmp
);
   // ***************************************************************
   // Comparators
   // ***************************************************************
   // No current flows while the output is off, so it reads below termination
   always_comb
   begin
      cmp.vbat_above_pre     = vbat_mv > 13'hAF0;
      cmp.vbat_at_float      = vbat_mv >= 13'h1068;
      cmp.vbat_below_rechg   = vbat_mv < 13'h1004;
      cmp.iout_below_term    = !out_en || taper_done;
      cmp.en_low             = ntc_pct < 7'h05;
      cmp.en_high            = ntc_pct > 7'h5F;
      cmp.ntc_hi_trip        = ntc_pct > 7'h4B;
      cmp.ntc_hi_ok          = ntc_pct < 7'h48;
      cmp.ntc_lo_trip        = ntc_pct < 7'h1E;
      cmp.ntc_lo_ok          = ntc_pct > 7'h21;
      cmp.tim_at_supply      = tim_pin == 2'h2;
      cmp.tim_at_ground      = tim_pin == 2'h0;
      cmp.battery_absent_sel = absent;
   end
endmodule : ccc_cell_model

// ---- ccc_ctrl_checker.sv ----
// Concurrent checks on the charge cycle controller ports.
// Assumes one pclk domain; filter plus state latency stays under eleven cycles.
`timescale 1ns/1ps
module ccc_ctrl_checker
   import ccc_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   input wire ccc_pkg::ccc_cmp_t cmp_raw,
   input wire logic              out_en,
   input wire logic              cv_mode,
   input wire logic              precharge_sel,
   input wire logic              regulator_mode,
   input wire logic              charge_status_led_n_o,
   input wire logic              charge_status_led_n_oe_n
);
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_led_open_drain: assert property (charge_status_led_n_o == 1'b0)
      else $error("status pin data not low");
   a_unmapped_err: assert property (psel && penable && paddr > ELAPSED_OFF |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_status_ro: assert property (psel && penable && pwrite && paddr == STATUS_OFF |-> pslverr)
      else $error("status write not refused");
   // Needs both windows clear, although regulator mode keeps the output on through a held thermistor fault
   a_regulate_on: assert property ((cmp_raw.battery_absent_sel && !cmp_raw.en_low && cmp_raw.ntc_hi_ok
      && cmp_raw.ntc_lo_ok) [*8] |-> ##3 (out_en && cv_mode && regulator_mode))
      else $error("regulator mode not entered");
   a_disable_off: assert property (cmp_raw.en_low [*8] |-> ##3 !out_en)
      else $error("output on while disabled");
   a_ntc_suspend: assert property ((cmp_raw.ntc_hi_trip && !cmp_raw.en_high
      && !cmp_raw.battery_absent_sel) [*8] |-> ##3 !out_en)
      else $error("output on during thermistor fault");
   a_precharge_low: assert property ((!cmp_raw.vbat_above_pre && !cmp_raw.battery_absent_sel) [*8]
      |-> ##3 (!out_en || precharge_sel))
      else $error("fast current with low cell");
   a_mode_exclusive: assert property (!(precharge_sel && cv_mode))
      else $error("pre-charge and constant voltage together");
endmodule : ccc_ctrl_checker

// ---- ccc_ctrl_test.sv ----
// Self-checking bench for the charge cycle controller: APB tasks and charge scenarios.
// Assumes the cell model on the comparator inputs and shortened tick and blink counts.
`timescale 1ns/1ps
module ccc_ctrl_test;
   import ccc_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic              out_en, cv, pre, regm, led_o, led_oe_n, taper, absent;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, e;
   logic [3:0]        pstrb;
   logic [12:0]       vbat;
   logic [6:0]        ntc;
   logic [1:0]        tim;
   ccc_cmp_t          cmp;
   int                error_cnt, checks, cyc;

   ccc_ctrl #(.TICKS(2), .BLINK_INT(6), .BLINK_HOUR(2), .FLEN(4)) ccc_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cmp_raw(cmp),
      .out_en(out_en), .cv_mode(cv), .precharge_sel(pre), .regulator_mode(regm),
      .charge_status_led_n_o(led_o), .charge_status_led_n_oe_n(led_oe_n));
   ccc_cell_model ccc_cell_model_inst (.vbat_mv(vbat), .ntc_pct(ntc), .tim_pin(tim), .taper_done(taper),
      .absent(absent), .out_en(out_en), .cmp(cmp));

   // ***************************************************************
   // Clock and timeout
   // ***************************************************************
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (cyc == 60000)
      begin
         error_cnt = error_cnt + 1;
         complete_run();
      end
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Starts one edge late so a release and the next setup never share a time step
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task settle();
      repeat (20) @(posedge pclk);
   endtask : settle

   task wait_out(input logic v, input int lim);
      int n;
      n = 0;
      while (out_en !== v && n < lim)
      begin
         @(posedge pclk);
         n = n + 1;
      end
      chk(32'(out_en), 32'(v));
   endtask : wait_out

   task blink(input int half);
      int n;
      n = 0;
      @(posedge led_oe_n);
      do
      begin
         @(negedge pclk);
         n = n + 1;
      end
      while (led_oe_n === 1'b1);
      chk(32'(n - 1), 32'(half));
   endtask : blink

   task complete_run();
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial
   begin
      {presetn, psel, penable, pwrite, taper, absent} = 6'h00;
      {paddr, pwdata, pstrb, tim} = {8'h00, 32'h0, 4'hF, 2'h2};
      {vbat, ntc, error_cnt, checks, cyc} = {13'hBB8, 7'h32, 32'h0, 32'h0, 32'h0};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFF, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, STATUS_OFF, 32'hFF);
      chk(32'(err), 32'h1);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      settle();
      chk(32'({out_en, cv, pre, led_oe_n}), 32'h8);
      vbat <= 13'h1068;
      settle();
      chk(32'({out_en, cv}), 32'h3);
      taper <= 1'b1;
      settle();
      chk(32'({out_en, led_oe_n}), 32'h3);
      taper <= 1'b0;
      settle();
      chk(32'(led_oe_n), 32'h1);
      ntc <= 7'h50;
      settle();
      chk(32'(out_en), 32'h0);
      blink(6);
      apb(1'b0, ELAPSED_OFF, 32'h0);
      e = rd;
      settle();
      apb(1'b0, ELAPSED_OFF, 32'h0);
      chk(rd, e);
      ntc <= 7'h4A;
      settle();
      chk(32'(out_en), 32'h0);
      ntc <= 7'h32;
      settle();
      chk(32'(out_en), 32'h1);
      wait_out(1'b0, 25000);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk(rd & 32'h7, 32'h5);
      apb(1'b0, ELAPSED_OFF, 32'h0);
      chk(rd, 32'h2A30);
      vbat <= 13'hFA0;
      settle();
      chk(32'({out_en, led_oe_n}), 32'h2);
      apb(1'b0, ELAPSED_OFF, 32'h0);
      chk(32'(rd < 32'h14), 32'h1);
      {tim, vbat} <= {2'h0, 13'h1068};
      settle();
      apb(1'b0, STATUS_OFF, 32'h0);
      chk((rd >> 10) & 32'h3, 32'h2);
      taper <= 1'b1;
      settle();
      chk(32'(out_en), 32'h0);
      tim <= 2'h1;
      apb(1'b1, CTRL_OFF, 32'h7);
      apb(1'b0, CTRL_OFF, 32'h0);
      chk(rd, 32'h7);
      apb(1'b1, CTRL_OFF, 32'h1);
      apb(1'b0, CTRL_OFF, 32'h0);
      chk(rd, 32'h1);
      {taper, vbat} <= {1'b0, 13'h7D0};
      settle();
      chk(32'({out_en, pre}), 32'h3);
      repeat (3000) @(posedge pclk);
      chk(32'(out_en), 32'h1);
      wait_out(1'b0, 1000);
      blink(4);
      vbat <= 13'hBB8;
      settle();
      chk(32'(out_en), 32'h1);
      absent <= 1'b1;
      settle();
      chk(32'({out_en, cv, regm}), 32'h7);
      ntc <= 7'h00;
      settle();
      chk(32'(out_en), 32'h0);
      ntc <= 7'h64;
      settle();
      chk(32'(out_en), 32'h1);
      complete_run();
   end
endmodule : ccc_ctrl_test
bind ccc_ctrl ccc_ctrl_checker ccc_ctrl_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .cmp_raw(cmp_raw), .out_en(out_en), .cv_mode(cv_mode),
   .precharge_sel(precharge_sel), .regulator_mode(regulator_mode),
   .charge_status_led_n_o(charge_status_led_n_o), .charge_status_led_n_oe_n(charge_status_led_n_oe_n));
